// ### address_map_mode_decoder.sv
// Purpose: Decodes fetch and operand addresses into ROM, RAM, peripheral or external targets,
//   takes the operating mode from the mode pins and owns the bus pin function registers.
// Assumes: Mode pins and the high-voltage detect come from pins; all other inputs are on ref_clk_i.
// Notes: Fetch, operand and vector results are registered and appear one cycle after the request.
//
// How it works
// - Pin a high, pin b low selects single-chip mode with ROM at zero.
// - High voltage on pin b with pin a high selects flash programming mode.
// - Address bits 31 to 28 are ignored; sixteen images of 256 MB.
// - Program counter keeps 26 bits; branch carry out of bit 25 dropped.
// - Operand address sum is truncated to 32 bits, wrapping to zero.
// - No instruction fetch from the peripheral area or its program-space image.
// - Only 128 KB of ROM exist; the rest of the 1 MB reads undefined.
// - An acknowledged interrupt or exception redirects to its fixed handler address.
// - Vectors: reset 0, illegal/debug 60H, first external 80H, 16-byte slots.
// - RAM answers only in its 6 KB; the rest of 12 KB is prohibited.
// - RAM is also seen through an image at 3FFC000H.
// - Peripherals live at FFFF000H; the 3FFF000H image is prohibited.
// - Peripheral decode ignores address bit 0.
// - Word peripheral access becomes two halfwords, lower first, low two bits ignored.
// - Halfword write to a byte register stores only the low byte.
// - External memory is 4 MB; starts at 100000H in single-chip mode.
// - Internal ROM, RAM and peripheral addresses never go to the external bus.
// - In ROMless mode bus pins leave reset in control mode, 16-bit bus.
// - In single-chip mode bus pins leave reset as general ports.
// - Each bus pin follows its own pin function register bit.
// - Pin function registers reset to ones (53H, 03H) ROMless, zero otherwise.
`timescale 1ns/1ns
`default_nettype none
`include "addr_map.svh"

module address_map_mode_decoder
  import addr_decode_pkg::*;
(
  input wire logic ref_clk_i,                        // System clock, 100 MHz.
  input wire logic rst_i,                            // Asynchronous reset, active high.
  input wire logic op_select_pin_a_i,                // Mode pin a.
  input wire logic op_select_pin_b_i,                // Mode pin b, logic level.
  input wire logic prog_volt_high_i,                 // Mode pin b at programming voltage.
  input wire logic fetch_req_i,                      // Fetch address request.
  input wire logic [31:0] fetch_base_i,              // Fetch base address.
  input wire logic [31:0] fetch_disp_i,              // Fetch displacement.
  input wire logic data_req_i,                       // Operand access request.
  input wire logic [31:0] data_base_i,               // Operand base address.
  input wire logic [31:0] data_disp_i,               // Operand displacement.
  input wire acc_size_t data_size_i,                 // Operand access size.
  input wire logic data_wr_i,                        // Operand write when high.
  input wire logic [31:0] data_wdata_i,              // Operand write data.
  input wire logic per_byte_reg_i,                   // Addressed peripheral register is byte wide.
  input wire logic [15:0] per_rdata_i,               // Peripheral halfword read data.
  input wire logic per_ack_i,                        // Peripheral halfword done.
  input wire logic vec_req_i,                        // Interrupt or exception acknowledged.
  input wire vec_kind_t vec_kind_i,                  // Source kind.
  input wire logic [5:0] vec_slot_i,                 // Maskable source slot.
  input wire logic pin_func_wr_i,                    // Pin function register write.
  input wire logic [1:0] pin_func_sel_i,             // 0 high data, 1 low data, 2 strobe, 3 handshake.
  input wire logic [15:0] pin_func_data_i,           // Pin function write data.
  output op_mode_t op_mode_o,                        // Captured operating mode.
  output logic mode_valid_o,                         // Mode has been captured.
  output logic mode_error_o,                         // Prohibited pin combination.
  output logic fetch_valid_o,                        // Fetch result valid pulse.
  output logic [25:0] fetch_addr_o,                  // Wrapped program address.
  output target_t fetch_target_o,                    // Fetch target.
  output logic fetch_refused_o,                      // Fetch not allowed here.
  output logic data_valid_o,                         // Operand result valid pulse.
  output logic [27:0] data_addr_o,                   // Physical operand address.
  output target_t data_target_o,                     // Operand target.
  output logic ext_req_o,                            // External bus request pulse.
  output logic [21:0] ext_addr_o,                    // External bus address.
  output logic per_req_o,                            // Peripheral halfword request.
  output logic [11:0] per_addr_o,                    // Peripheral halfword offset.
  output logic per_wr_o,                             // Peripheral halfword write.
  output logic [15:0] per_wdata_o,                   // Peripheral halfword write data.
  output logic [31:0] per_rdata_o,                   // Gathered peripheral read data.
  output logic per_done_o,                           // Peripheral access done pulse.
  output logic vec_valid_o,                          // Handler address valid pulse.
  output logic [31:0] vec_addr_o,                    // Handler address.
  output logic vec_external_o,                       // Handler lies in external memory.
  output logic [7:0] data_high_pin_function_reg_o,   // Upper data port pin functions.
  output logic [15:0] data_low_pin_function_reg_o,   // Lower data port pin functions.
  output logic [7:0] bus_strobe_pin_function_reg_o,  // Strobe port pin functions.
  output logic [7:0] bus_handshake_pin_function_reg_o // Handshake port pin functions.
);

  // ----------------------------------------------------------------
  // Mode capture
  // ----------------------------------------------------------------
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic [1:0] cap_cnt_q;
  op_mode_t mode_d;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
    end else begin
      pin_meta_q <= {prog_volt_high_i, op_select_pin_b_i, op_select_pin_a_i};
      pin_sync_q <= pin_meta_q;
    end
  end

  always_comb begin
    if (pin_sync_q[2] && pin_sync_q[0]) begin
      mode_d = MODE_FLASH;
    end else if (!pin_sync_q[2] && !pin_sync_q[1] && pin_sync_q[0]) begin
      mode_d = MODE_SINGLE;
    end else if (!pin_sync_q[2] && !pin_sync_q[1] && !pin_sync_q[0]) begin
      mode_d = MODE_ROMLESS;
    end else begin
      mode_d = MODE_PROHIB;
    end
  end

  // The pins are taken once; later changes are not followed since they are to stay fixed.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cap_cnt_q <= 2'h0;
      mode_valid_o <= 1'b0;
      op_mode_o <= MODE_PROHIB;
      mode_error_o <= 1'b0;
    end else if (!mode_valid_o) begin
      if (cap_cnt_q == `MODE_CAPTURE_CYCLES) begin
        mode_valid_o <= 1'b1;
        op_mode_o <= mode_d;
        mode_error_o <= (mode_d == MODE_PROHIB);
      end else begin
        cap_cnt_q <= cap_cnt_q + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin function registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_high_pin_function_reg_o <= 8'h00;
      data_low_pin_function_reg_o <= 16'h0000;
      bus_strobe_pin_function_reg_o <= 8'h00;
      bus_handshake_pin_function_reg_o <= 8'h00;
    end else if (!mode_valid_o) begin
      if (cap_cnt_q == `MODE_CAPTURE_CYCLES && mode_d == MODE_ROMLESS) begin
        data_high_pin_function_reg_o <= `DATA_HIGH_CTRL_RST;
        data_low_pin_function_reg_o <= `DATA_LOW_CTRL_RST;
        bus_strobe_pin_function_reg_o <= `BUS_STROBE_CTRL_RST;
        bus_handshake_pin_function_reg_o <= `BUS_HANDSHAKE_CTRL_RST;
      end
    end else if (pin_func_wr_i) begin
      unique case (pin_func_sel_i)
        2'h0: data_high_pin_function_reg_o <= pin_func_data_i[7:0];
        2'h1: data_low_pin_function_reg_o <= pin_func_data_i;
        2'h2: bus_strobe_pin_function_reg_o <= pin_func_data_i[7:0];
        2'h3: bus_handshake_pin_function_reg_o <= pin_func_data_i[7:0];
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // External cycles need at least one strobe pin in control mode; in single-chip mode
  // that happens only after software reprograms them.
  logic ext_en;
  assign ext_en = |bus_strobe_pin_function_reg_o;

  function automatic target_t decode(input logic [27:0] a, input op_mode_t m, input logic en);
    target_t t;
    t = TGT_NONE;
    if (m == MODE_PROHIB) begin
      t = TGT_NONE;
    end else if (a >= `PER_BASE) begin
      t = TGT_PERIPH;
    end else if (a >= `RAM_PROHIB_BASE) begin
      t = (a >= `RAM_BASE) ? TGT_PROHIB : TGT_NONE;
    end else if (a >= `RAM_BASE) begin
      t = TGT_RAM;
    end else if (a >= `PER_IMG_BASE && a <= `PER_IMG_END) begin
      t = TGT_PROHIB;
    end else if (a > `RAM_IMG_PHYS_END && a <= `RAM_IMG_AREA_END) begin
      t = TGT_PROHIB;
    end else if (a >= `RAM_IMG_BASE && a <= `RAM_IMG_PHYS_END) begin
      t = TGT_RAM;
    end else if (m != MODE_ROMLESS && a <= `ROM_AREA_END) begin
      t = (a <= `ROM_PHYS_END) ? TGT_ROM : TGT_UNDEF;
    end else if (a <= `EXT_AREA_END && en) begin
      t = TGT_EXT;
    end
    return t;
  endfunction : decode

  logic [25:0] pc_sum;
  logic [31:0] op_sum;
  target_t fetch_tgt;
  target_t data_tgt;
  logic split_busy;

  assign pc_sum = fetch_base_i[25:0] + fetch_disp_i[25:0];
  assign op_sum = data_base_i + data_disp_i;
  assign fetch_tgt = decode({2'b00, pc_sum}, op_mode_o, ext_en);
  assign data_tgt = decode(op_sum[27:0], op_mode_o, ext_en);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fetch_valid_o <= 1'b0;
      fetch_addr_o <= 26'h0000000;
      fetch_target_o <= TGT_NONE;
      fetch_refused_o <= 1'b0;
    end else begin
      fetch_valid_o <= fetch_req_i && mode_valid_o;
      if (fetch_req_i && mode_valid_o) begin
        fetch_addr_o <= pc_sum;
        fetch_target_o <= fetch_tgt;
        fetch_refused_o <= (pc_sum >= `PER_PROG_BASE) || (fetch_tgt == TGT_PERIPH);
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_valid_o <= 1'b0;
      data_addr_o <= 28'h0000000;
      data_target_o <= TGT_NONE;
      ext_req_o <= 1'b0;
      ext_addr_o <= 22'h000000;
    end else begin
      data_valid_o <= data_req_i && mode_valid_o;
      ext_req_o <= data_req_i && mode_valid_o && data_tgt == TGT_EXT;
      if (data_req_i && mode_valid_o) begin
        data_addr_o <= op_sum[27:0];
        data_target_o <= data_tgt;
        ext_addr_o <= op_sum[21:0];
      end
    end
  end

  periph_split u_split (
    .clk_i(ref_clk_i),
    .rst_i(rst_i),
    .start_i(data_req_i && mode_valid_o && data_tgt == TGT_PERIPH && !split_busy),
    .addr_i(op_sum[11:0]),
    .size_i(data_size_i),
    .wr_i(data_wr_i),
    .wdata_i(data_wdata_i),
    .byte_reg_i(per_byte_reg_i),
    .rdata_i(per_rdata_i),
    .ack_i(per_ack_i),
    .req_o(per_req_o),
    .addr_o(per_addr_o),
    .wr_o(per_wr_o),
    .wdata_o(per_wdata_o),
    .rdata_o(per_rdata_o),
    .done_o(per_done_o),
    .busy_o(split_busy)
  );

  // ----------------------------------------------------------------
  // Vector table
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      vec_valid_o <= 1'b0;
      vec_addr_o <= `VEC_RESET_ADDR;
      vec_external_o <= 1'b0;
    end else begin
      vec_valid_o <= vec_req_i;
      if (vec_req_i) begin
        vec_external_o <= (op_mode_o == MODE_ROMLESS);
        unique case (vec_kind_i)
          VEC_RESET: vec_addr_o <= `VEC_RESET_ADDR;
          VEC_NMI: vec_addr_o <= `VEC_NMI_ADDR;
          VEC_TRAP_A: vec_addr_o <= `VEC_TRAP_A_ADDR;
          VEC_TRAP_B: vec_addr_o <= `VEC_TRAP_B_ADDR;
          VEC_ILLEGAL: vec_addr_o <= `VEC_ILLEGAL_ADDR;
          VEC_MASKABLE: vec_addr_o <= `VEC_IRQ_BASE + {22'h000000, vec_slot_i, 4'h0};
          default: vec_addr_o <= `VEC_RESET_ADDR;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  mode_single_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (fetch_valid_o && op_mode_o == MODE_SINGLE && fetch_addr_o <= 26'h001FFFF) |-> fetch_target_o == TGT_ROM)
    else $error("single-chip fetch near zero missed the ROM");

  mode_stable_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    mode_valid_o |=> (mode_valid_o && $stable(op_mode_o)))
    else $error("captured mode changed");

  romless_pins_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ($rose(mode_valid_o) && op_mode_o == MODE_ROMLESS) |-> (bus_strobe_pin_function_reg_o == 8'h53
      && bus_handshake_pin_function_reg_o == 8'h03 && data_low_pin_function_reg_o == 16'hFFFF))
    else $error("ROMless pin function reset values wrong");

  fetch_wrap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (fetch_req_i && mode_valid_o) |=> (fetch_valid_o && fetch_addr_o == 26'($past(fetch_base_i + fetch_disp_i))))
    else $error("fetch address not wrapped to 26 bits");

  fetch_image_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (fetch_valid_o && fetch_addr_o >= 26'h3FFF000) |-> fetch_refused_o)
    else $error("fetch from peripheral image not refused");

  data_image_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (data_req_i && mode_valid_o) |=> data_addr_o == 28'($past(data_base_i + data_disp_i)))
    else $error("operand physical address wrong");

  ram_window_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (data_valid_o && data_target_o == TGT_RAM) |-> ((data_addr_o >= 28'hFFFC000 && data_addr_o <= 28'hFFFD7FF)
      || (data_addr_o >= 28'h3FFC000 && data_addr_o <= 28'h3FFD7FF)))
    else $error("RAM target outside physical RAM");

  ext_only_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ext_req_o |-> (data_target_o == TGT_EXT && data_addr_o <= 28'h03FFFFF
      && (op_mode_o == MODE_ROMLESS || data_addr_o >= 28'h0100000)))
    else $error("external request for an internal address");

  vec_illegal_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (vec_req_i && vec_kind_i == VEC_ILLEGAL) |=> (vec_valid_o && vec_addr_o == 32'h00000060))
    else $error("illegal opcode vector wrong");

endmodule : address_map_mode_decoder

`default_nettype wire

// ### addr_map.svh
// Purpose: Address bounds, vector slots, reset values and timing counts of the address map decoder.
// Assumes: Physical addresses are 28 bits wide, program addresses 26 bits wide.
// Notes: Definitions only; included by its bare name.
`ifndef ADDR_MAP_SVH
`define ADDR_MAP_SVH

// Physical map, 28-bit.
`define ROM_PHYS_END 28'h001FFFF
`define ROM_AREA_END 28'h00FFFFF
`define EXT_SINGLE_BASE 28'h0100000
`define EXT_AREA_END 28'h03FFFFF
`define RAM_BASE 28'hFFFC000
`define RAM_PHYS_END 28'hFFFD7FF
`define RAM_PROHIB_BASE 28'hFFFD800
`define PER_BASE 28'hFFFF000
`define RAM_IMG_BASE 28'h3FFC000
`define RAM_IMG_PHYS_END 28'h3FFD7FF
`define RAM_IMG_AREA_END 28'h3FFEFFF
`define PER_IMG_BASE 28'h3FFF000
`define PER_IMG_END 28'h3FFFFFF

// Program space image of the peripheral area, 26-bit.
`define PER_PROG_BASE 26'h3FFF000

// Vector slots.
`define VEC_RESET_ADDR 32'h00000000
`define VEC_NMI_ADDR 32'h00000010
`define VEC_TRAP_A_ADDR 32'h00000040
`define VEC_TRAP_B_ADDR 32'h00000050
`define VEC_ILLEGAL_ADDR 32'h00000060
`define VEC_IRQ_BASE 32'h00000080

// Pin function register reset values in control mode.
`define DATA_HIGH_CTRL_RST 8'hFF
`define DATA_LOW_CTRL_RST 16'hFFFF
`define BUS_STROBE_CTRL_RST 8'h53
`define BUS_HANDSHAKE_CTRL_RST 8'h03

// Cycles from reset release until the mode pins are taken.
`define MODE_CAPTURE_CYCLES 2'h2

`endif

// ### addr_decode_pkg.sv
// Purpose: Types shared by the address map decoder and its peripheral splitter.
// Assumes: Nothing beyond the map header.
// Notes: Enumerations carry explicit binary codes.
package addr_decode_pkg;

  typedef enum logic [1:0] {
    MODE_ROMLESS = 2'b00,
    MODE_SINGLE = 2'b01,
    MODE_FLASH = 2'b10,
    MODE_PROHIB = 2'b11
  } op_mode_t;

  typedef enum logic [2:0] {
    TGT_NONE = 3'b000,
    TGT_ROM = 3'b001,
    TGT_RAM = 3'b010,
    TGT_PERIPH = 3'b011,
    TGT_EXT = 3'b100,
    TGT_UNDEF = 3'b101,
    TGT_PROHIB = 3'b110
  } target_t;

  typedef enum logic [2:0] {
    VEC_RESET = 3'b000,
    VEC_NMI = 3'b001,
    VEC_TRAP_A = 3'b010,
    VEC_TRAP_B = 3'b011,
    VEC_ILLEGAL = 3'b100,
    VEC_MASKABLE = 3'b101
  } vec_kind_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_HALF = 2'b01,
    SZ_WORD = 2'b10
  } acc_size_t;

  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_LOW = 2'b01,
    SP_HIGH = 2'b10
  } split_state_t;

endpackage : addr_decode_pkg

// ### periph_split.sv
// Purpose: Turns one operand access to the peripheral area into one or two halfword cycles.
// Assumes: The peripheral side holds ack_i high for one cycle per halfword.
// Notes: A start while busy is ignored; the caller watches busy_o.
`timescale 1ns/1ns
`default_nettype none
`include "addr_map.svh"

module periph_split
  import addr_decode_pkg::*;
(
  input wire logic clk_i,           // System clock.
  input wire logic rst_i,           // Asynchronous reset, active high.
  input wire logic start_i,         // Start a peripheral access.
  input wire logic [11:0] addr_i,   // Offset inside the peripheral area.
  input wire acc_size_t size_i,     // Access size.
  input wire logic wr_i,            // Write when high.
  input wire logic [31:0] wdata_i,  // Write data.
  input wire logic byte_reg_i,      // Target register is byte wide.
  input wire logic [15:0] rdata_i,  // Halfword read data.
  input wire logic ack_i,           // Halfword cycle done.
  output logic req_o,               // Halfword cycle request.
  output logic [11:0] addr_o,       // Halfword cycle offset.
  output logic wr_o,                // Halfword cycle write.
  output logic [15:0] wdata_o,      // Halfword cycle write data.
  output logic [31:0] rdata_o,      // Gathered read data.
  output logic done_o,              // Access complete pulse.
  output logic busy_o               // Access in progress.
);

  split_state_t state_q;
  logic word_q;
  logic [15:0] upper_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= SP_IDLE;
      word_q <= 1'b0;
      upper_q <= 16'h0000;
      req_o <= 1'b0;
      addr_o <= 12'h000;
      wr_o <= 1'b0;
      wdata_o <= 16'h0000;
      rdata_o <= 32'h00000000;
      done_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (state_q)
        SP_IDLE: begin
          if (start_i) begin
            state_q <= SP_LOW;
            busy_o <= 1'b1;
            req_o <= 1'b1;
            wr_o <= wr_i;
            word_q <= (size_i == SZ_WORD);
            upper_q <= wdata_i[31:16];
            if (size_i == SZ_WORD) begin
              addr_o <= {addr_i[11:2], 2'b00};
            end else begin
              addr_o <= {addr_i[11:1], 1'b0};
            end
            if (byte_reg_i && size_i == SZ_HALF) begin
              wdata_o <= {8'h00, wdata_i[7:0]};
            end else begin
              wdata_o <= wdata_i[15:0];
            end
          end
        end
        SP_LOW: begin
          if (ack_i) begin
            rdata_o <= {16'h0000, rdata_i};
            if (word_q) begin
              state_q <= SP_HIGH;
              addr_o <= {addr_o[11:2], 2'b10};
              wdata_o <= upper_q;
            end else begin
              state_q <= SP_IDLE;
              req_o <= 1'b0;
              busy_o <= 1'b0;
              done_o <= 1'b1;
            end
          end
        end
        SP_HIGH: begin
          if (ack_i) begin
            rdata_o <= {rdata_i, rdata_o[15:0]};
            state_q <= SP_IDLE;
            req_o <= 1'b0;
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end
        end
        default: begin
          state_q <= SP_IDLE;
          req_o <= 1'b0;
          busy_o <= 1'b0;
        end
      endcase
    end
  end

  lsb_ignored_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req_o |-> addr_o[0] == 1'b0)
    else $error("peripheral cycle with odd offset");

  word_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == SP_LOW && ack_i && word_q) |=> (req_o && addr_o[1:0] == 2'b10 && state_q == SP_HIGH))
    else $error("word access did not follow with the upper halfword");

endmodule : periph_split

`default_nettype wire

// ### periph_ack_model.sv
// Purpose: Peripheral side model that answers each halfword cycle.
// Assumes: The request stays high until the final acknowledge.
// Notes: Waits three cycles per halfword; read data is only valid with the ack.
`timescale 1ns/1ns
`default_nettype none
module periph_ack_model (
  input wire logic clk_i,         // System clock.
  input wire logic rst_i,         // Asynchronous reset, active high.
  input wire logic req_i,         // Halfword request.
  input wire logic [11:0] addr_i, // Halfword offset.
  output logic ack_o,             // One-cycle done.
  output logic [15:0] rdata_o     // Read data.
);
  logic [1:0] wait_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_q <= 2'h0;
      ack_o <= 1'b0;
      rdata_o <= 16'h0000;
    end else begin
      wait_q <= (req_i && !ack_o) ? wait_q + 2'h1 : 2'h0;
      ack_o <= req_i && !ack_o && wait_q == 2'h2;
      // Outside the ack the data is inverted, so stale values never look valid.
      rdata_o <= (req_i && wait_q == 2'h2) ? {4'hA, addr_i} : ~{4'hA, addr_i};
    end
  end
endmodule : periph_ack_model
`default_nettype wire

// ### address_map_mode_decoder_tb_top.sv
// Purpose: Self-checking bench for the address map decoder in all modes.
// Assumes: Mode pins change only under reset; the peripheral side is the ack model.
// Notes: Expected values come from the map.
`timescale 1ns/1ns
`default_nettype none
module address_map_mode_decoder_tb_top;
  import addr_decode_pkg::*;
  logic ref_clk_i = 0, rst_i = 1, prog_volt_high_i = 0, op_select_pin_b_i = 0;
  logic op_select_pin_a_i = 1;
  logic fetch_req_i = 0, data_req_i = 0, data_wr_i = 1, per_byte_reg_i = 0, vec_req_i = 0, pin_func_wr_i = 0;
  logic [31:0] fetch_base_i = 0, fetch_disp_i = 0, data_base_i = 0, data_disp_i = 0, data_wdata_i = 0;
  acc_size_t data_size_i = SZ_BYTE;
  vec_kind_t vec_kind_i = VEC_RESET;
  logic [5:0] vec_slot_i = 0;
  logic [1:0] pin_func_sel_i = 0;
  logic [15:0] pin_func_data_i = 0, per_rdata_i, per_wdata_o, data_low_pin_function_reg_o;
  logic per_ack_i, mode_valid_o, mode_error_o, fetch_valid_o, fetch_refused_o, data_valid_o, ext_req_o;
  logic per_req_o, per_wr_o, per_done_o, vec_valid_o, vec_external_o;
  op_mode_t op_mode_o;
  target_t fetch_target_o, data_target_o;
  logic [25:0] fetch_addr_o;
  logic [27:0] data_addr_o;
  logic [21:0] ext_addr_o;
  logic [11:0] per_addr_o;
  logic [31:0] per_rdata_o, vec_addr_o;
  logic [7:0] data_high_pin_function_reg_o, bus_strobe_pin_function_reg_o, bus_handshake_pin_function_reg_o;
  int n_mismatch = 0, cmp_count = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  address_map_mode_decoder i_dut (.*);
  periph_ack_model i_per (.clk_i(ref_clk_i), .rst_i(rst_i), .req_i(per_req_o), .addr_i(per_addr_o),
    .ack_o(per_ack_i), .rdata_o(per_rdata_i));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  task automatic fetch(input logic [31:0] b, input logic [31:0] d, input logic [31:0] ea, input logic [31:0] er);
    @(posedge ref_clk_i);
    fetch_req_i <= 1;
    fetch_base_i <= b;
    fetch_disp_i <= d;
    @(posedge ref_clk_i);
    fetch_req_i <= 0;
    #1;
    check(fetch_valid_o, 1);
    check(fetch_addr_o, ea);
    check(fetch_refused_o, er);
  endtask : fetch
  task automatic data(input logic [31:0] b, input acc_size_t s, input logic [31:0] tgt, input logic [31:0] ad);
    @(posedge ref_clk_i);
    data_req_i <= 1;
    data_base_i <= b;
    data_disp_i <= (b == 32'hFFFFFFF0) ? 32'h00000010 : 32'h00000000;
    data_size_i <= s;
    data_wdata_i <= 32'h12345678;
    @(posedge ref_clk_i);
    data_req_i <= 0;
    #1;
    check(data_valid_o, 1);
    check(data_target_o, tgt);
    check(data_addr_o, ad);
    check(ext_req_o, tgt == TGT_EXT);
  endtask : data
  task automatic vec(input vec_kind_t k, input logic [5:0] sl, input logic [31:0] ea);
    @(posedge ref_clk_i);
    vec_req_i <= 1;
    vec_kind_i <= k;
    vec_slot_i <= sl;
    @(posedge ref_clk_i);
    vec_req_i <= 0;
    #1;
    check(vec_valid_o, 1);
    check(vec_addr_o, ea);
  endtask : vec
  task automatic wait_high(ref logic s);
    do begin
      @(posedge ref_clk_i);
      #1;
    end while (s !== 1);
  endtask : wait_high
  task automatic restart(input logic [2:0] pins, input op_mode_t m);
    rst_i <= 1;
    {prog_volt_high_i, op_select_pin_b_i, op_select_pin_a_i} <= pins;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 0;
    wait_high(mode_valid_o);
    check({mode_error_o, op_mode_o}, {m == MODE_PROHIB, m});
  endtask : restart
  initial begin
    #30000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 0;
    wait_high(mode_valid_o);
    check(op_mode_o, MODE_SINGLE);
    check({bus_strobe_pin_function_reg_o, data_low_pin_function_reg_o}, 0);
    check({data_high_pin_function_reg_o, bus_handshake_pin_function_reg_o}, 0);
    fetch(32'h03FFFFF0, 32'h20, 32'h10, 0);
    fetch(32'h03FFF000, 0, 32'h3FFF000, 1);
    fetch(32'h0FFFF010, 0, 32'h3FFF010, 1);
    data(32'hFFFFFFF0, SZ_BYTE, TGT_ROM, 0);
    data(32'h1FFFC010, SZ_HALF, TGT_RAM, 28'hFFFC010);
    data(32'h00020000, SZ_BYTE, TGT_UNDEF, 28'h0020000);
    data(32'h0FFFD800, SZ_BYTE, TGT_PROHIB, 28'hFFFD800);
    data(32'h03FFC000, SZ_BYTE, TGT_RAM, 28'h3FFC000);
    data(32'h03FFF000, SZ_BYTE, TGT_PROHIB, 28'h3FFF000);
    vec(VEC_RESET, 0, 0);
    vec(VEC_ILLEGAL, 0, 32'h60);
    vec(VEC_MASKABLE, 6'h01, 32'h90);
    @(posedge ref_clk_i);
    pin_func_wr_i <= 1;
    pin_func_sel_i <= 2'h2;
    pin_func_data_i <= 16'h0053;
    @(posedge ref_clk_i);
    pin_func_wr_i <= 0;
    #1;
    check(bus_strobe_pin_function_reg_o, 32'h53);
    data(32'h00100000, SZ_BYTE, TGT_EXT, 28'h0100000);
    data(32'h00000010, SZ_BYTE, TGT_ROM, 28'h0000010);
    data(32'hFFFFF102, SZ_WORD, TGT_PERIPH, 28'hFFFF102);
    check({per_req_o, per_addr_o, per_wdata_o}, {1'b1, 12'h100, 16'h5678});
    wait_high(per_ack_i);
    @(posedge ref_clk_i);
    #1;
    check({per_req_o, per_addr_o, per_wdata_o}, {1'b1, 12'h102, 16'h1234});
    wait_high(per_done_o);
    check(per_rdata_o, 32'hA102A100);
    data(32'hFFFFF105, SZ_BYTE, TGT_PERIPH, 28'hFFFF105);
    check(per_addr_o, 12'h104);
    wait_high(per_done_o);
    per_byte_reg_i <= 1;
    data(32'hFFFFF106, SZ_HALF, TGT_PERIPH, 28'hFFFF106);
    check(per_wdata_o, 8'h78);
    wait_high(per_done_o);
    restart(3'b000, MODE_ROMLESS);
    check({data_high_pin_function_reg_o, bus_strobe_pin_function_reg_o}, 16'hFF53);
    check({bus_handshake_pin_function_reg_o, data_low_pin_function_reg_o}, 24'h03FFFF);
    data(16, SZ_BYTE, TGT_EXT, 16);
    vec(VEC_RESET, 0, 0);
    check(vec_external_o, 1);
    restart(3'b111, MODE_FLASH);
    restart(3'b010, MODE_PROHIB);
    data(16, SZ_BYTE, TGT_NONE, 16);
    finish_test();
  end
endmodule : address_map_mode_decoder_tb_top
`default_nettype wire
